// ---- hdl/ivs_regs.svh ----
// Register offsets, reset values and source tables of the vector select block
`ifndef IVS_REGS_SVH
`define IVS_REGS_SVH

`define IVS_OFF_EXT_CTRL  32'h0000_0008
`define IVS_OFF_STATUS    32'h0000_000C
`define IVS_OFF_CLEAR     32'h0000_0010
`define IVS_OFF_ENABLE    32'h0000_0014
`define IVS_OFF_STATE     32'h0000_0018

`define IVS_EXT_CTRL_RST  8'h00
`define IVS_ENABLE_RST    8'h00
`define IVS_STATUS_RST    8'h00

`define IVS_VEC_BASE      16'hFFF0
`define IVS_MASKABLE      8'h3F
`define IVS_WAKE_SRC      8'hB0
`define IVS_PEND_RST      8'h80
`define IVS_SRC_SCI       1
`define IVS_SRC_TWI       2

`define IVS_RESP_OKAY     2'h0
`define IVS_RESP_SLVERR   2'h2

`endif

// ---- hdl/ivs_pkg.sv ----
// Types shared by the vector select block, the core model and the bench
package ivs_pkg;

  // Commands from the processor core, one-cycle pulses
  typedef struct packed {
    logic ack;
    logic return_from_service;
    logic mask_set;
    logic mask_clear;
  } ivs_core_cmd_t;

  // Answer to the processor core
  typedef struct packed {
    logic        req;
    logic [15:0] vector;
    logic        mask;
    logic        wake;
  } ivs_core_resp_t;

  typedef enum logic [2:0] {
    IVS_SRC_USB, IVS_SRC_SCI, IVS_SRC_TWI, IVS_SRC_TIM,
    IVS_SRC_EXT, IVS_SRC_EOS, IVS_SRC_TRAP, IVS_SRC_RST
  } ivs_src_t;

endpackage

// ---- hdl/ivs_axil_slave.sv ----
// AXI4-Lite slave front end that turns bus transfers into register strobes
`include "ivs_regs.svh"
module ivs_axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             reg_wr,
  output logic [31:0]      reg_waddr,
  output logic [31:0]      reg_wdata,
  output logic [3:0]       reg_wstrb,
  input  wire logic        reg_werr,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rerr
);
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic        ar_take;

  assign reg_waddr = awaddr_q;
  assign reg_wdata = wdata_q;
  assign reg_wstrb = wstrb_q;
  assign reg_wr    = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign ar_take   = s_axi_arvalid & s_axi_arready;

  // Address and data taken in either order; response only after both
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (reg_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = reg_werr ? `IVS_RESP_SLVERR : `IVS_RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // One write at a time: hold ready low until the response is gone
    awready_d = ~aw_have_d & ~bvalid_d & ~reg_wr;
    wready_d  = ~w_have_d & ~bvalid_d & ~reg_wr;
  end

  // Read data captured at address acceptance, one cycle to rvalid
  always_comb begin
    rvalid_d  = s_axi_rvalid;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = reg_rerr ? 32'h0000_0000 : reg_rdata;
      rresp_d  = reg_rerr ? `IVS_RESP_SLVERR : `IVS_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = ~rvalid_d & ~ar_take;
  end

  // Register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 32'h0000_0000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IVS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `IVS_RESP_OKAY;
    end else begin
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
    end
  end
endmodule

// ---- hdl/ivs_top.sv ----
// Interrupt vector select: pending latches, mask, priority, wake and registers
// Summary of operation
// - The eight external request lines share vector FFF8h, are maskable and wake from halt.
// - The USB end-of-suspend event selects vector FFFAh, is maskable and wakes from halt.
// - The software trap selects vector FFFCh, ignores the mask and never wakes from halt.
// - Serial and two-wire sources raise nothing on variants without those peripherals.
// - Requests arriving under the mask stay pending and are served once it clears.
// - Entering service sets the mask; it blocks all but the trap and reset; software or return clears it.
//
// Implementation choice: the AXI4-Lite slave port.
`include "ivs_regs.svh"
module ivs_top #(
  parameter bit HAS_SCI = 1'b1,
  parameter bit HAS_TWI = 1'b1
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            external_request_lines,
  input  wire logic                  usb_evt,
  input  wire logic                  sci_evt,
  input  wire logic                  twi_evt,
  input  wire logic                  tim_evt,
  input  wire logic                  eos_evt,
  input  wire logic                  trap_evt,
  input  wire ivs_pkg::ivs_core_cmd_t core_cmd,
  output ivs_pkg::ivs_core_resp_t    core_resp,
  output logic                       irq,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  import ivs_pkg::*;

  logic [7:0]     ev, pend_q, pend_d, clr_pend, eligible;
  logic [7:0]     ext_ctrl_q, ext_ctrl_d, stat_q, stat_d, en_q, en_d;
  logic           mask_d, irq_d;
  ivs_core_resp_t resp_d;
  ivs_src_t       sel;
  logic           reg_wr, reg_werr, reg_rerr;
  logic [31:0]    reg_waddr, reg_wdata, reg_rdata;
  logic [3:0]     reg_wstrb;
  logic           served;

  // ************************************************************
  // Bus slave
  // ************************************************************
  ivs_axil_slave i_ivs_axil_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .reg_wr        (reg_wr),
    .reg_waddr     (reg_waddr),
    .reg_wdata     (reg_wdata),
    .reg_wstrb     (reg_wstrb),
    .reg_werr      (reg_werr),
    .reg_rdata     (reg_rdata),
    .reg_rerr      (reg_rerr)
  );

  // ************************************************************
  // Sources and pending latches
  // ************************************************************
  // Event vector indexed by source; absent peripherals tied off
  always_comb begin
    ev                = 8'h00;
    ev[IVS_SRC_USB]   = usb_evt;
    ev[IVS_SRC_SCI]   = HAS_SCI & sci_evt;
    ev[IVS_SRC_TWI]   = HAS_TWI & twi_evt;
    ev[IVS_SRC_TIM]   = tim_evt;
    ev[IVS_SRC_EXT]   = |(external_request_lines & ext_ctrl_q);
    ev[IVS_SRC_EOS]   = eos_evt;
    ev[IVS_SRC_TRAP]  = trap_evt;
  end

  // Only an acknowledge of a live request retires its source
  assign served = core_cmd.ack & core_resp.req;

  // Per-source latch: a new event beats the service clear
  for (genvar i = 0; i < 8; i++) begin : g_pend
    assign clr_pend[i] = served && (core_resp.vector[3:1] == 3'(i));
    assign pend_d[i]   = ev[i] | (pend_q[i] & ~clr_pend[i]);
    assign stat_d[i]   = ev[i] | (stat_q[i] &
                         ~(reg_wr && reg_waddr == `IVS_OFF_CLEAR && reg_wdata[i]));
  end

  // ************************************************************
  // Mask, priority and vector
  // ************************************************************
  // Mask blocks maskable sources only; trap and reset pass
  assign eligible = pend_q & ~(core_resp.mask ? `IVS_MASKABLE : 8'h00);

  // Highest source index wins; reset first, then the trap
  always_comb begin
    sel = IVS_SRC_USB;
    for (int k = 0; k < 8; k++) begin
      if (eligible[k]) sel = ivs_src_t'(k[2:0]);
    end
  end

  // Mask: entry sets it, software or return clears it; entry wins
  always_comb begin
    mask_d = core_resp.mask;
    if (core_cmd.mask_clear || core_cmd.return_from_service) mask_d = 1'b0;
    if (core_cmd.mask_set || served) mask_d = 1'b1;
  end

  // Vector is base plus two bytes per source index
  always_comb begin
    resp_d.req    = |eligible;
    resp_d.vector = `IVS_VEC_BASE | {12'h000, sel, 1'b0};
    resp_d.mask   = mask_d;
    resp_d.wake   = |(eligible & `IVS_WAKE_SRC);
    irq_d         = |(stat_d & en_d);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_comb begin
    ext_ctrl_d = ext_ctrl_q;
    en_d       = en_q;
    if (reg_wr && reg_wstrb[0] && reg_waddr == `IVS_OFF_EXT_CTRL) ext_ctrl_d = reg_wdata[7:0];
    if (reg_wr && reg_wstrb[0] && reg_waddr == `IVS_OFF_ENABLE) en_d = reg_wdata[7:0];
  end

  // Read mux; clear register is write-only and reads zero
  always_comb begin
    reg_rerr = 1'b0;
    unique case (s_axi_araddr)
      `IVS_OFF_EXT_CTRL: reg_rdata = {24'h00_0000, ext_ctrl_q};
      `IVS_OFF_STATUS:   reg_rdata = {24'h00_0000, stat_q};
      `IVS_OFF_CLEAR:    reg_rdata = 32'h0000_0000;
      `IVS_OFF_ENABLE:   reg_rdata = {24'h00_0000, en_q};
      `IVS_OFF_STATE:    reg_rdata = {8'h00, pend_q, core_resp.vector};
      default: begin
        reg_rdata = 32'h0000_0000;
        reg_rerr  = 1'b1;
      end
    endcase
  end

  assign reg_werr = !(reg_waddr == `IVS_OFF_EXT_CTRL || reg_waddr == `IVS_OFF_CLEAR ||
                      reg_waddr == `IVS_OFF_ENABLE || reg_waddr == `IVS_OFF_STATUS ||
                      reg_waddr == `IVS_OFF_STATE);

  // State stage; mask comes out of reset set so no maskable source fires early
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q           <= `IVS_PEND_RST;
      stat_q           <= `IVS_STATUS_RST;
      en_q             <= `IVS_ENABLE_RST;
      ext_ctrl_q       <= `IVS_EXT_CTRL_RST;
      core_resp.req    <= 1'b0;
      core_resp.vector <= `IVS_VEC_BASE;
      core_resp.mask   <= 1'b1;
      core_resp.wake   <= 1'b0;
      irq              <= 1'b0;
    end else begin
      pend_q     <= pend_d;
      stat_q     <= stat_d;
      en_q       <= en_d;
      ext_ctrl_q <= ext_ctrl_d;
      core_resp  <= resp_d;
      irq        <= irq_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ext_vector_a: assert property (
    core_resp.req && core_resp.vector == 16'hFFF8 |-> core_resp.wake)
    else $error("ext vector without wake");
  eos_masked_a: assert property (
    core_resp.mask && $stable(core_resp.mask) |=>
    core_resp.vector != 16'hFFFA || !core_resp.req)
    else $error("eos under mask");
  trap_pass_a: assert property (
    $rose(trap_evt) && !pend_q[7] ##1 !served |=> core_resp.req)
    else $error("trap not requested");
  // Trap alone pending: other wake sources may legally share the cycle
  trap_nowake_a: assert property (pend_q == 8'h40 |=> !core_resp.wake)
    else $error("trap woke part");
  variant_off_a: assert property ((HAS_SCI || !pend_q[1]) && (HAS_TWI || !pend_q[2]))
    else $error("absent peripheral pending");
  vec_range_a: assert property (
    core_resp.req |-> core_resp.vector[15:4] == 12'hFFF && !core_resp.vector[0])
    else $error("bad vector");
  pend_hold_a: assert property (pend_q[0] && !clr_pend[0] |=> pend_q[0])
    else $error("pending lost");
  entry_mask_a: assert property (
    served |=> core_resp.mask ##1 core_resp.mask ||
    $past(core_cmd.mask_clear || core_cmd.return_from_service))
    else $error("mask");

  trap_cov_c: cover property (trap_evt ##[1:4] served);
  ext_cov_c:  cover property (ev[4] && core_resp.mask ##[1:20] served);
  irq_cov_c:  cover property ($rose(irq));
endmodule

// ---- verification/ivs_core_model.sv ----
// Processor core model: fetches vectors and drives the mask commands
module ivs_core_model (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire ivs_pkg::ivs_core_resp_t core_resp,
  input  wire logic                    clr_req,
  input  wire logic                    ret_req,
  input  wire logic                    set_req,
  input  wire logic [1:0]              ack_delay,
  output ivs_pkg::ivs_core_cmd_t       core_cmd,
  output logic                         fetch_valid,
  output logic [15:0]                  fetch_vec,
  output logic                         fetch_wake
);
  import ivs_pkg::*;
  logic [1:0] wait_q;
  logic [1:0] hold_q;

  // ****
  // Fetch
  // ****
  // Ack after a chosen delay, then rest so a stale request is not taken twice
  always_ff @(posedge aclk) begin
    core_cmd <= '0;
    fetch_valid <= 1'b0;
    if (!aresetn) begin
      wait_q <= '0;
      hold_q <= '0;
    end else begin
      core_cmd.mask_clear <= clr_req;
      core_cmd.return_from_service <= ret_req;
      core_cmd.mask_set <= set_req;
      if (core_cmd.ack) begin
        fetch_valid <= 1'b1;
        fetch_vec <= core_resp.vector;
        fetch_wake <= core_resp.wake;
        hold_q <= 2'h3;
      end else if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end else if (core_resp.req && wait_q >= ack_delay) begin
        core_cmd.ack <= 1'b1;
        wait_q <= '0;
      end else if (core_resp.req) begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// ---- verification/tb_interrupt_vector_select.sv ----
// Self-checking bench for the interrupt vector select block
`include "ivs_regs.svh"
module tb_interrupt_vector_select;
  timeunit 1ns;
  timeprecision 1ns;
  import ivs_pkg::*;
  logic           aclk, aresetn, irq, clr_req, ret_req, set_req;
  logic           usb_evt, sci_evt, twi_evt, tim_evt, eos_evt, trap_evt;
  logic [7:0]     external_request_lines, en;
  logic [1:0]     ack_delay, s_axi_bresp, s_axi_rresp;
  ivs_core_cmd_t  core_cmd;
  ivs_core_resp_t core_resp;
  logic [31:0]    s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]     s_axi_wstrb;
  logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic           s_axi_rvalid, s_axi_rready, fetch_valid, fetch_wake;
  logic [15:0]    fetch_vec;
  logic [35:0]    exp_q[$];
  int             err_count, checked, fetch_cnt, nf;
  integer         seed = 32'ha718_74b3;
  localparam logic [15:0] vec_tab [8] = '{16'hFFF0, 16'hFFF2, 16'hFFF4, 16'hFFF6,
                                           16'hFFF8, 16'hFFFA, 16'hFFFC, 16'hFFFE};
  localparam logic [7:0]  wake_tab = 8'hB0;

  // Serial present, two-wire absent, so the variant tie-off is exercised
  ivs_top #(.HAS_SCI(1'b1), .HAS_TWI(1'b0)) i_ivs_top (.*);
  ivs_core_model i_ivs_core_model (.*);

  // Free-running clock, 100 ns period
  always #50 aclk = ~aclk;

  // ****
  // Tasks
  // ****
  task automatic report_and_stop();
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic take(input logic [35:0] seen);
    logic [35:0] e;
    e = ~seen;
    if (exp_q.size() != 0) e = exp_q.pop_front();
    chk(seen, e);
  endtask

  task automatic expect_fetch(input int i);
    exp_q.push_back({2'h2, 1'b0, wake_tab[i], 16'h0000, vec_tab[i]});
  endtask

  task automatic wait_fetch();
    int n;
    n = 0;
    nf++;
    while (fetch_cnt < nf && n < 200) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 200) err_count++;
  endtask

  task automatic pulse(input logic [6:0] ev, input logic [7:0] ln);
    {trap_evt, eos_evt, tim_evt, twi_evt, sci_evt, usb_evt} <= {ev[6:5], ev[3:0]};
    external_request_lines <= ln;
    @(posedge aclk);
    {trap_evt, eos_evt, tim_evt, twi_evt, sci_evt, usb_evt} <= 6'h00;
    external_request_lines <= 8'h00;
  endtask

  task automatic unmask(input bit ret, input bit look);
    clr_req <= !ret;
    ret_req <= ret;
    @(posedge aclk);
    clr_req <= 1'b0;
    ret_req <= 1'b0;
    repeat (3) @(posedge aclk);
    if (look) chk(36'(core_resp.mask), 36'h0);
  endtask

  task automatic irq_is(input logic v);
    repeat (3) @(posedge aclk);
    chk(36'(irq), 36'(v));
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back({2'h1, r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    if (n >= 100) err_count++;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back({2'h0, r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    if (n >= 100) err_count++;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Results in arrival order against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) take({2'h0, s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) take({2'h1, s_axi_bresp, 32'h0000_0000});
    if (fetch_valid) take({2'h2, 1'b0, fetch_wake, 16'h0000, fetch_vec});
    if (fetch_valid) fetch_cnt++;
  end

  // Hang guard, far beyond the few hundred cycles of the sequence
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    report_and_stop();
  end

  // ****
  // Sequence
  // ****
  initial begin
    int j;
    aclk = 1'b0;
    {aresetn, clr_req, ret_req, set_req, ack_delay} = '0;
    {trap_evt, eos_evt, tim_evt, twi_evt, sci_evt, usb_evt} = '0;
    external_request_lines = 8'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    expect_fetch(7);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wait_fetch();
    repeat (3) @(posedge aclk);
    unmask(1'b1, 1'b1);
    axi_rd(`IVS_OFF_EXT_CTRL, `IVS_EXT_CTRL_RST, `IVS_RESP_OKAY);
    axi_rd(`IVS_OFF_ENABLE, 8'h00, `IVS_RESP_OKAY);
    axi_rd(32'h0000_001C, 8'h00, `IVS_RESP_SLVERR);
    axi_wr(32'h0000_0020, 8'h5A, `IVS_RESP_SLVERR);
    axi_wr(`IVS_OFF_STATUS, 8'hFF, `IVS_RESP_OKAY);
    j = $random(seed) & 7;
    en = 8'($random(seed));
    en[j] = 1'b1;
    axi_wr(`IVS_OFF_EXT_CTRL, en, `IVS_RESP_OKAY);
    axi_rd(`IVS_OFF_EXT_CTRL, en, `IVS_RESP_OKAY);
    // Disabled lines must stay silent
    pulse(7'h00, ~en);
    repeat (4) @(posedge aclk);
    chk(36'(core_resp.req), 36'h0);
    // Every source but reset once, prompt and slow fetches mixed
    for (int i = 0; i < 7; i++) begin
      ack_delay <= 2'($random(seed));
      if (i != 2) expect_fetch(i);
      pulse(7'(1 << i), (i == 4) ? 8'(1 << j) : 8'h00);
      if (i == 2) begin
        // Absent two-wire peripheral: its event must raise nothing
        repeat (4) @(posedge aclk);
        chk(36'(core_resp.req), 36'h0);
        chk(36'(core_resp.mask), 36'h0);
        chk(36'(core_resp.wake), 36'h0);
      end else begin
        wait_fetch();
        repeat (3) @(posedge aclk);
        chk(36'(core_resp.mask), 36'h1);
        unmask(1'b0, 1'b1);
      end
    end
    // Pair in one cycle, then timer and trap under the mask
    expect_fetch(5);
    pulse(7'h21, 8'h00);
    wait_fetch();
    pulse(7'h08, 8'h00);
    repeat (5) @(posedge aclk);
    chk(36'(core_resp.req), 36'h0);
    expect_fetch(6);
    pulse(7'h40, 8'h00);
    wait_fetch();
    expect_fetch(3);
    expect_fetch(0);
    unmask(1'b0, 1'b0);
    wait_fetch();
    unmask(1'b1, 1'b0);
    wait_fetch();
    // Software sets the mask: a timer event waits until it clears
    unmask(1'b0, 1'b1);
    set_req <= 1'b1;
    @(posedge aclk);
    set_req <= 1'b0;
    pulse(7'h08, 8'h00);
    repeat (4) @(posedge aclk);
    chk(36'(core_resp.mask), 36'h1);
    chk(36'(core_resp.req), 36'h0);
    expect_fetch(3);
    unmask(1'b0, 1'b0);
    wait_fetch();
    // Sticky status, enable and clear of the interrupt line
    axi_rd(`IVS_OFF_STATUS, 8'h7B, `IVS_RESP_OKAY);
    irq_is(1'b0);
    axi_wr(`IVS_OFF_ENABLE, 8'h08, `IVS_RESP_OKAY);
    irq_is(1'b1);
    axi_wr(`IVS_OFF_CLEAR, 8'h08, `IVS_RESP_OKAY);
    irq_is(1'b0);
    axi_rd(`IVS_OFF_STATUS, 8'h73, `IVS_RESP_OKAY);
    axi_wr(`IVS_OFF_ENABLE, 8'h01, `IVS_RESP_OKAY);
    irq_is(1'b1);
    axi_rd(`IVS_OFF_ENABLE, 8'h01, `IVS_RESP_OKAY);
    axi_wr(`IVS_OFF_ENABLE, 8'h00, `IVS_RESP_OKAY);
    irq_is(1'b0);
    axi_wr(`IVS_OFF_CLEAR, 8'hFF, `IVS_RESP_OKAY);
    axi_rd(`IVS_OFF_STATUS, 8'h00, `IVS_RESP_OKAY);
    // Nothing pending: state shows empty latches and the lowest vector
    axi_rd(`IVS_OFF_STATE, 32'h0000_FFF0, `IVS_RESP_OKAY);
    chk(36'(exp_q.size()), 36'h0);
    report_and_stop();
  end
endmodule
